// ---- logic/crip_div.sv ----
// enable-pulse divider, one pulse every DIV clocks while enabled
`timescale 1ns/1ps
module crip_div
#(
	parameter int DIV = 2
)
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic en,
	output logic      tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= '0;
		else if (en)
			cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + CW'(1);
	end

	assign tick = en && (cnt_ff == LAST);
endmodule

// ---- logic/crip_pkg.sv ----
// constants, field layouts and carrier types of the clock, reset and interrupt pin logic
package crip_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          APB_AW           = 8;
	localparam int          APB_DW           = 32;
	localparam logic [7:0]  ADDR_OPTION2     = 8'h00;
	localparam logic [7:0]  ADDR_FLAGS       = 8'h04;
	localparam logic [7:0]  ADDR_STATUS      = 8'h08;
	localparam logic [7:0]  ADDR_ACK         = 8'h0C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          OPT_E_OFF        = 0;
	localparam int          OPT_QUAD_EN      = 1;
	localparam int          OPT_EDGE_SEL     = 2;
	localparam int          OPT_STOP         = 3;
	localparam int          FLG_NMI_MASK     = 0;
	localparam int          FLG_IRQ_MASK     = 1;
	localparam int          ACK_EDGE         = 0;
	localparam int          STS_RST_EXT      = 0;
	localparam int          STS_IRQ_PEND     = 1;
	localparam int          STS_NMI_PEND     = 2;
	localparam int          STS_HALTED       = 3;
	localparam int          STS_E_LEVEL      = 4;
	localparam int          STS_RST_PIN      = 5;
	localparam int          STS_SINGLE_CHIP  = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic        RST_E_OFF        = 1'b0;
	localparam logic        RST_QUAD_EN      = 1'b1;
	localparam logic        RST_EDGE_SEL     = 1'b0;
	localparam logic        RST_NMI_MASK     = 1'b1;
	localparam logic        RST_IRQ_MASK     = 1'b1;
	localparam logic        RST_EXT_FLAG     = 1'b0;
	localparam logic        PIN_IDLE         = 1'b1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          OSC_DIV          = 2;
	localparam int          QUAD_PER_E       = 4;
	localparam int          TICKS_PER_QUAD   = 2;
	localparam int          TICKS_PER_E      = QUAD_PER_E * TICKS_PER_QUAD;
	localparam int          E_PH_W           = $clog2(TICKS_PER_E);
	localparam logic [2:0]  E_PH_LAST_LOW    = 3'(TICKS_PER_E / 2 - 1);
	localparam int          CNT_W            = 4;
	localparam logic [3:0]  INTERNAL_LIMIT_E = 4'h2;
	localparam logic [3:0]  RST_DRIVE_E      = 4'h4;
	localparam int          SYNC_W           = 4;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic request_edge_select;
		logic quad_clock_enable_bit;
		logic e_clock_off;
	} crip_option_s;

	typedef struct packed
	{
		logic irq_mask;
		logic nmi_mask;
	} crip_flags_s;

	typedef enum logic [3:0]
	{
		ST_RUN    = 4'b0001,
		ST_DRIVE  = 4'b0010,
		ST_SENSE  = 4'b0100,
		ST_EXTRST = 4'b1000
	} crip_state_e;

endpackage

// ---- logic/crip_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module crip_sync
#(
	parameter int         WIDTH   = 1,
	parameter logic [0:0] RST_VAL = 1'b1
)
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= {WIDTH{RST_VAL}};
			sync_ff <= {WIDTH{RST_VAL}};
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ---- logic/crip_top.sv ----
// clock outputs, reset pin handling and external interrupt request inputs
`timescale 1ns/1ps

// What this block does
// R1 - low reset pin resets core, registers and requests, not the clock dividers
// R2 - monitor or watchdog failure pulls pin low
// R3 - pin high within two E: internal reset
// R4 - E clock is oscillator tick divided by eight
// R5 - E low internal work, high data access
// R6 - halt mode stops every clock output
// R7 - E output switchable off in single-chip
// R8 - quad clock on after reset, bit disables
// R9 - maskable request edge or level by bit
// R10 - reset selects level triggering
// R11 - reset sets nonmaskable mask bit
// R12 - nonmaskable request sensed by level
// R13 - shared maskable line needs level triggering
// R14 - sharing sources drive open-drain only
// R15 - source holds line low until acknowledged
// R16 - still-low line re-requests when unmasked
// R17 - fully static, any clock down to zero
// R18 - synchronise both request inputs first
module crip_top
	import crip_pkg::*;
#(
	parameter int OSC_DIVIDE = crip_pkg::OSC_DIV
)
(
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic [crip_pkg::APB_AW-1:0] paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [crip_pkg::APB_DW-1:0] pwdata,
	output logic      [crip_pkg::APB_DW-1:0] prdata,
	output logic                          pready,
	output logic                          pslverr,
	// bidirectional open-drain reset pin
	input  wire logic                     reset_pin_in,
	output logic                          reset_pin_out,
	output logic                          reset_pin_oe_n,
	// clock outputs
	output logic                          e_clock_out,
	output logic                          quad_rate_clock_out,
	// interrupt request pins, active low
	input  wire logic                     irq_pin_n,
	input  wire logic                     nonmaskable_request_pin_n,
	// mode and failure inputs
	input  wire logic                     single_chip_mode,
	input  wire logic                     clock_monitor_fail,
	input  wire logic                     watchdog_fail,
	// towards the core
	output logic                          internal_reset_n,
	output logic                          data_access_phase,
	output logic                          maskable_int_req,
	output logic                          nonmask_int_req,
	output logic                          clocks_halted
);
	import crip_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	crip_state_e            state_ff;
	crip_state_e            nxt_state;
	crip_option_s           option_ff;
	crip_flags_s            flags_ff;
	logic [CNT_W-1:0]       e_cnt_ff;
	logic [CNT_W-1:0]       nxt_e_cnt;
	logic                   rst_external_ff;
	logic                   halted_ff;
	logic [E_PH_W-1:0]      e_ph_ff;
	logic                   quad_ff;
	logic                   e_clock_out_ff;
	logic                   quad_out_ff;
	logic                   data_access_ff;
	logic                   irq_prev_ff;
	logic                   edge_latch_ff;
	logic                   mask_req_ff;
	logic                   nmi_req_ff;
	logic                   int_rst_n_ff;
	logic                   oe_n_ff;
	logic [APB_DW-1:0]      prdata_ff;
	logic [SYNC_W-1:0]      pins_async;
	logic [SYNC_W-1:0]      pins_sync;
	logic                   rst_pin_s;
	logic                   irq_s;
	logic                   nmi_s;
	logic                   single_chip_s;
	logic                   osc_tick;
	logic                   e_rise;
	logic                   e_level;
	logic                   sys_rst;
	logic                   fail;
	logic                   wr_en;
	logic                   rd_setup;
	logic                   addr_hit;
	logic                   irq_fall;
	logic                   irq_pending;
	logic                   nmi_pending;
	logic                   ack_edge;
	logic                   stop_wr;
	logic                   wake;
	logic [APB_DW-1:0]      rd_mux;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	assign pins_async = {single_chip_mode, nonmaskable_request_pin_n, irq_pin_n, reset_pin_in};

	crip_sync #(
		.WIDTH   (SYNC_W),
		.RST_VAL (PIN_IDLE)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pins_async),
		.sync_out (pins_sync)
	); // [R18]

	assign rst_pin_s     = pins_sync[0];
	assign irq_s         = pins_sync[1];
	assign nmi_s         = pins_sync[2];
	assign single_chip_s = pins_sync[3];

	// ----------------------------------------------------------------
	// oscillator tick, halted in stop mode
	// ----------------------------------------------------------------
	crip_div #(
		.DIV (OSC_DIVIDE)
	) u_osc_div (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (!halted_ff),
		.tick    (osc_tick)
	); // [R6] [R17]

	// ----------------------------------------------------------------
	// E and quad-rate clock generation
	// ----------------------------------------------------------------
	// quad clock toggles every tick; E spans four quad periods
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			e_ph_ff <= '0;
			quad_ff <= 1'b0;
		end
		else if (osc_tick)
		begin
			e_ph_ff <= e_ph_ff + E_PH_W'(1); // [R4]
			quad_ff <= !quad_ff; // [R8]
		end
	end

	assign e_level = e_ph_ff[E_PH_W-1];
	assign e_rise  = osc_tick && (e_ph_ff == E_PH_LAST_LOW);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			e_clock_out_ff <= 1'b0;
			quad_out_ff    <= 1'b0;
			data_access_ff <= 1'b0;
		end
		else
		begin
			// outputs forced low while halted
			e_clock_out_ff <= e_level && !halted_ff
				&& !(option_ff.e_clock_off && single_chip_s); // [R6] [R7]
			quad_out_ff    <= quad_ff && !halted_ff && option_ff.quad_clock_enable_bit; // [R6] [R8]
			data_access_ff <= e_level && !halted_ff; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// reset pin state machine
	// ----------------------------------------------------------------
	assign fail    = clock_monitor_fail || watchdog_fail;
	assign sys_rst = (state_ff != ST_RUN);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_e_cnt = e_cnt_ff;
		unique case (state_ff)
			ST_RUN:
			begin
				nxt_e_cnt = '0;
				if (fail)
					nxt_state = ST_DRIVE; // [R2]
				else if (!rst_pin_s)
					nxt_state = ST_EXTRST; // [R1]
			end
			ST_DRIVE:
			begin
				if (e_rise)
				begin
					if (e_cnt_ff == RST_DRIVE_E - CNT_W'(1))
					begin
						nxt_state = ST_SENSE;
						nxt_e_cnt = '0;
					end
					else
						nxt_e_cnt = e_cnt_ff + CNT_W'(1);
				end
			end
			ST_SENSE:
			begin
				if (rst_pin_s)
					nxt_state = ST_RUN; // [R3]
				else if (e_rise)
				begin
					if (e_cnt_ff == INTERNAL_LIMIT_E - CNT_W'(1))
						nxt_state = ST_EXTRST; // [R3]
					else
						nxt_e_cnt = e_cnt_ff + CNT_W'(1);
				end
			end
			ST_EXTRST:
			begin
				if (rst_pin_s)
					nxt_state = ST_RUN; // [R1]
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_RUN;
			e_cnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			e_cnt_ff <= nxt_e_cnt;
		end
	end

	// reset type survives the internal reset it describes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_external_ff <= RST_EXT_FLAG;
		else if (sys_rst && nxt_state == ST_RUN)
			rst_external_ff <= (state_ff == ST_EXTRST); // [R3]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			oe_n_ff      <= 1'b1;
			int_rst_n_ff <= 1'b0;
		end
		else
		begin
			oe_n_ff      <= !(nxt_state == ST_DRIVE); // [R2]
			int_rst_n_ff <= (nxt_state == ST_RUN); // [R1]
		end
	end

	// ----------------------------------------------------------------
	// apb access decode
	// ----------------------------------------------------------------
	assign wr_en    = psel && penable && pwrite && !sys_rst;
	assign rd_setup = psel && !penable && !pwrite;
	assign addr_hit = (paddr == ADDR_OPTION2) || (paddr == ADDR_FLAGS)
		|| (paddr == ADDR_STATUS) || (paddr == ADDR_ACK);
	assign stop_wr  = wr_en && (paddr == ADDR_OPTION2) && pwdata[OPT_STOP];
	assign ack_edge = wr_en && (paddr == ADDR_ACK) && pwdata[ACK_EDGE];

	// ----------------------------------------------------------------
	// option and condition flag registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			option_ff.e_clock_off           <= RST_E_OFF;
			option_ff.quad_clock_enable_bit <= RST_QUAD_EN; // [R8]
			option_ff.request_edge_select   <= RST_EDGE_SEL; // [R10]
		end
		else if (sys_rst)
		begin
			option_ff.e_clock_off           <= RST_E_OFF;
			option_ff.quad_clock_enable_bit <= RST_QUAD_EN; // [R8]
			option_ff.request_edge_select   <= RST_EDGE_SEL; // [R10]
		end
		else if (wr_en && paddr == ADDR_OPTION2)
		begin
			option_ff.e_clock_off           <= pwdata[OPT_E_OFF]; // [R7]
			option_ff.quad_clock_enable_bit <= pwdata[OPT_QUAD_EN]; // [R8]
			option_ff.request_edge_select   <= pwdata[OPT_EDGE_SEL]; // [R9]
		end
	end

	// nonmaskable mask can only be cleared by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_ff.nmi_mask <= RST_NMI_MASK;
			flags_ff.irq_mask <= RST_IRQ_MASK;
		end
		else if (sys_rst)
		begin
			flags_ff.nmi_mask <= RST_NMI_MASK; // [R11]
			flags_ff.irq_mask <= RST_IRQ_MASK;
		end
		else if (wr_en && paddr == ADDR_FLAGS)
		begin
			flags_ff.nmi_mask <= flags_ff.nmi_mask && pwdata[FLG_NMI_MASK]; // [R11]
			flags_ff.irq_mask <= pwdata[FLG_IRQ_MASK];
		end
	end

	// ----------------------------------------------------------------
	// interrupt request sensing
	// ----------------------------------------------------------------
	assign irq_fall = irq_prev_ff && !irq_s;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_prev_ff   <= PIN_IDLE;
			edge_latch_ff <= 1'b0;
		end
		else if (sys_rst)
		begin
			irq_prev_ff   <= irq_s;
			edge_latch_ff <= 1'b0;
		end
		else
		begin
			irq_prev_ff <= irq_s;
			// a new edge wins over a simultaneous acknowledge
			if (option_ff.request_edge_select && irq_fall)
				edge_latch_ff <= 1'b1; // [R9]
			else if (ack_edge || !option_ff.request_edge_select)
				edge_latch_ff <= 1'b0;
		end
	end

	// level mode follows the line, so a held line re-requests
	assign irq_pending = option_ff.request_edge_select ? edge_latch_ff : !irq_s; // [R9] [R13] [R15]
	assign nmi_pending = !nmi_s; // [R12]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_req_ff <= 1'b0;
			nmi_req_ff  <= 1'b0;
		end
		else
		begin
			mask_req_ff <= irq_pending && !flags_ff.irq_mask && !sys_rst; // [R16]
			nmi_req_ff  <= nmi_pending && !flags_ff.nmi_mask && !sys_rst; // [R11] [R12] [R14]
		end
	end

	// ----------------------------------------------------------------
	// stop mode
	// ----------------------------------------------------------------
	assign wake = (irq_pending && !flags_ff.irq_mask) || (nmi_pending && !flags_ff.nmi_mask);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			halted_ff <= 1'b0;
		else if (sys_rst || fail || wake)
			halted_ff <= 1'b0;
		else if (stop_wr)
			halted_ff <= 1'b1; // [R6]
	end

	// ----------------------------------------------------------------
	// apb read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_mux = '0;
		unique case (paddr)
			ADDR_OPTION2:
			begin
				rd_mux[OPT_E_OFF]    = option_ff.e_clock_off;
				rd_mux[OPT_QUAD_EN]  = option_ff.quad_clock_enable_bit;
				rd_mux[OPT_EDGE_SEL] = option_ff.request_edge_select;
			end
			ADDR_FLAGS:
			begin
				rd_mux[FLG_NMI_MASK] = flags_ff.nmi_mask;
				rd_mux[FLG_IRQ_MASK] = flags_ff.irq_mask;
			end
			ADDR_STATUS:
			begin
				rd_mux[STS_RST_EXT]     = rst_external_ff;
				rd_mux[STS_IRQ_PEND]    = irq_pending;
				rd_mux[STS_NMI_PEND]    = nmi_pending;
				rd_mux[STS_HALTED]      = halted_ff;
				rd_mux[STS_E_LEVEL]     = e_level;
				rd_mux[STS_RST_PIN]     = rst_pin_s;
				rd_mux[STS_SINGLE_CHIP] = single_chip_s;
			end
			default:
			begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= '0;
		else if (rd_setup)
			prdata_ff <= rd_mux;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata              = prdata_ff;
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && !addr_hit;
	assign reset_pin_out       = 1'b0; // [R2]
	assign reset_pin_oe_n      = oe_n_ff;
	assign e_clock_out         = e_clock_out_ff;
	assign quad_rate_clock_out = quad_out_ff;
	assign internal_reset_n    = int_rst_n_ff;
	assign data_access_phase   = data_access_ff;
	assign maskable_int_req    = mask_req_ff;
	assign nonmask_int_req     = nmi_req_ff;
	assign clocks_halted       = halted_ff;
endmodule

// ---- test/crip_checker.sv ----
// concurrent assertions on the ports of the clock, reset and interrupt block
`timescale 1ns/1ps
module crip_checker
	import crip_pkg::*;
#(
	parameter int OSC_DIVIDE = crip_pkg::OSC_DIV
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	input wire logic e_clock_out,
	input wire logic quad_rate_clock_out,
	input wire logic nonmaskable_request_pin_n,
	input wire logic clock_monitor_fail,
	input wire logic watchdog_fail,
	// core side
	input wire logic internal_reset_n,
	input wire logic data_access_phase,
	input wire logic nonmask_int_req,
	input wire logic clocks_halted
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	localparam int E_HALF  = 4 * OSC_DIVIDE;
	localparam int DRV_MAX = 40 * OSC_DIVIDE;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pin_low_only: assert property (reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	a_fail_drive: assert property (internal_reset_n && (clock_monitor_fail || watchdog_fail)
		|=> !reset_pin_oe_n && !internal_reset_n) else $error("failure did not pull reset pin");
	a_drive_span: assert property ($fell(reset_pin_oe_n)
		|-> !reset_pin_oe_n [*8] ##[1:DRV_MAX] reset_pin_oe_n) else $error("reset drive length wrong");
	a_drive_core: assert property (!reset_pin_oe_n |-> !internal_reset_n)
		else $error("core out of reset while pin driven");
	a_pin_resets: assert property (!reset_pin_in [*3] |-> ##[1:2] !internal_reset_n)
		else $error("low reset pin did not reset core");
	a_e_high_span: assert property ($rose(e_clock_out) |-> ##E_HALF !e_clock_out)
		else $error("e clock high phase length wrong");
	a_access_phase: assert property (e_clock_out |-> data_access_phase)
		else $error("e high without data access phase");
	a_halt_quiet: assert property (clocks_halted && $past(clocks_halted)
		|-> !e_clock_out && !quad_rate_clock_out) else $error("clock running while halted");
	a_nmi_cause: assert property (nonmask_int_req |-> !$past(nonmaskable_request_pin_n, 3))
		else $error("nonmaskable request without low pin");
endmodule

bind crip_top crip_checker #(.OSC_DIVIDE(OSC_DIVIDE)) u_chk (.pclk, .presetn, .reset_pin_in, .reset_pin_out,
	.reset_pin_oe_n, .e_clock_out, .quad_rate_clock_out, .nonmaskable_request_pin_n, .clock_monitor_fail,
	.watchdog_fail, .internal_reset_n, .data_access_phase, .nonmask_int_req, .clocks_halted);

// ---- test/crip_far_side.sv ----
// reset circuit and open-drain interrupt sources around the pins
`timescale 1ns/1ps
module crip_far_side
(
	// clock
	input  wire logic       pclk,
	// device side of the pins
	input  wire logic       reset_pin_out,
	input  wire logic       reset_pin_oe_n,
	output logic            reset_pin_in,
	output logic            irq_pin_n,
	output logic            nonmaskable_request_pin_n,
	// scenario controls
	input  wire logic       switch_press,
	input  wire logic       slow_rise,
	input  wire logic [2:0] raise,
	input  wire logic [2:0] ack
);
	logic [2:0] hold_ff = 3'h0;
	logic [4:0] rc_ff   = 5'h00;

	// sources hold their request until acknowledged
	always @(posedge pclk)
		hold_ff <= (hold_ff | raise) & ~ack;
	// slow pull-up keeps the pin low after the device lets go
	always @(posedge pclk)
		rc_ff <= !reset_pin_oe_n ? (slow_rise ? 5'h1F : 5'h00) : ((rc_ff != 5'h00) ? rc_ff - 5'h01 : 5'h00);
	// wired lines, one pull-up each, sources only pull low
	assign reset_pin_in = !(switch_press || rc_ff != 5'h00 || (!reset_pin_oe_n && !reset_pin_out));
	assign irq_pin_n = !(hold_ff[0] || hold_ff[1]);
	assign nonmaskable_request_pin_n = !hold_ff[2];
endmodule

// ---- test/crip_tb_top.sv ----
// self-checking bench for the clock, reset and interrupt pin block
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module crip_tb_top;
	import crip_pkg::*;
	localparam int DIV = 1;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic [31:0] m; logic e;} crip_row_s;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        reset_pin_in, reset_pin_out, reset_pin_oe_n, e_clock_out, quad_rate_clock_out;
	logic        irq_pin_n, nonmaskable_request_pin_n, single_chip_mode, clock_monitor_fail, watchdog_fail;
	logic        internal_reset_n, data_access_phase, maskable_int_req, nonmask_int_req, clocks_halted;
	logic        switch_press, slow_rise;
	logic [2:0]  raise, ack;
	int          error_cnt, total_checks, cyc, e_n, q_n, n;
	crip_row_s   rows [11] = '{
		'{ADDR_OPTION2, 1'b0, 32'h0, 32'h2, 32'hF, 1'b0},
		'{ADDR_FLAGS, 1'b0, 32'h0, 32'h3, 32'h3, 1'b0},
		'{ADDR_STATUS, 1'b0, 32'h0, 32'h20, 32'h2F, 1'b0},
		'{ADDR_FLAGS, 1'b1, 32'h0, 32'h0, 32'h0, 1'b0},
		'{ADDR_FLAGS, 1'b0, 32'h0, 32'h0, 32'h3, 1'b0},
		'{ADDR_FLAGS, 1'b1, 32'h3, 32'h0, 32'h0, 1'b0},
		'{ADDR_FLAGS, 1'b0, 32'h0, 32'h2, 32'h3, 1'b0},
		'{ADDR_OPTION2, 1'b1, 32'h6, 32'h0, 32'h0, 1'b0},
		'{ADDR_OPTION2, 1'b0, 32'h0, 32'h6, 32'hF, 1'b0},
		'{ADDR_OPTION2, 1'b1, 32'h2, 32'h0, 32'h0, 1'b0},
		'{8'h10, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1}};

	crip_top #(.OSC_DIVIDE(DIV)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .e_clock_out, .quad_rate_clock_out,
		.irq_pin_n, .nonmaskable_request_pin_n, .single_chip_mode, .clock_monitor_fail, .watchdog_fail,
		.internal_reset_n, .data_access_phase, .maskable_int_req, .nonmask_int_req, .clocks_halted);
	crip_far_side u_far (.pclk, .reset_pin_out, .reset_pin_oe_n, .reset_pin_in, .irq_pin_n,
		.nonmaskable_request_pin_n, .switch_press, .slow_rise, .raise, .ack);

	// ----------------------------------------------------------------
	// clock, edge counters, timeout
	// ----------------------------------------------------------------
	always #4 pclk = ~pclk;
	always @(posedge e_clock_out) e_n++;
	always @(posedge quad_rate_clock_out) q_n++;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [2:0] r, input logic [2:0] k);
		@(posedge pclk);
		raise <= r;
		ack <= k;
		@(posedge pclk);
		raise <= 3'h0;
		ack <= 3'h0;
	endtask

	task automatic meas(input int ex_e, input int ex_q);
		int e0;
		int q0;
		repeat (4) @(posedge pclk);
		e0 = e_n;
		q0 = q_n;
		repeat (64) @(posedge pclk);
		`CHK(e_n - e0, ex_e)
		`CHK(q_n - q0, ex_q)
	endtask

	task automatic fail_once(input logic mon);
		@(posedge pclk);
		clock_monitor_fail <= mon;
		watchdog_fail <= !mon;
		@(posedge pclk);
		clock_monitor_fail <= 1'b0;
		watchdog_fail <= 1'b0;
		@(posedge pclk);
		`CHK(reset_pin_oe_n, 1'b0)
		`CHK(internal_reset_n, 1'b0)
		n = 0;
		while (internal_reset_n !== 1'b1 && n < 300)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(n < 300, 1'b1)
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{single_chip_mode, clock_monitor_fail, watchdog_fail, switch_press, slow_rise, raise, ack} = '0;
		{error_cnt, total_checks, cyc, e_n, q_n} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			`CHK(rd & rows[i].m, rows[i].x)
			`CHK(err, rows[i].e)
		end
		meas(64 / (8 * DIV), 256 / (8 * DIV));
		apb(ADDR_OPTION2, 1'b1, 32'h1);
		meas(64 / (8 * DIV), 0);
		single_chip_mode <= 1'b1;
		meas(0, 0);
		single_chip_mode <= 1'b0;
		apb(ADDR_OPTION2, 1'b1, 32'h2);
		// two sources share the line in level mode
		pulse(3'h3, 3'h0);
		repeat (4) @(posedge pclk);
		`CHK(maskable_int_req, 1'b0)
		apb(ADDR_FLAGS, 1'b1, 32'h0);
		repeat (4) @(posedge pclk);
		`CHK(maskable_int_req, 1'b1)
		pulse(3'h0, 3'h1);
		repeat (4) @(posedge pclk);
		`CHK(maskable_int_req, 1'b1)
		apb(ADDR_FLAGS, 1'b1, 32'h2);
		repeat (2) @(posedge pclk);
		`CHK(maskable_int_req, 1'b0)
		apb(ADDR_FLAGS, 1'b1, 32'h0);
		repeat (4) @(posedge pclk);
		`CHK(maskable_int_req, 1'b1)
		pulse(3'h0, 3'h2);
		repeat (4) @(posedge pclk);
		`CHK(maskable_int_req, 1'b0)
		pulse(3'h4, 3'h0);
		repeat (4) @(posedge pclk);
		`CHK(nonmask_int_req, 1'b1)
		apb(ADDR_FLAGS, 1'b1, 32'h1);
		`CHK(nonmask_int_req, 1'b1)
		pulse(3'h0, 3'h4);
		repeat (4) @(posedge pclk);
		`CHK(nonmask_int_req, 1'b0)
		// falling edge is latched until cleared
		apb(ADDR_OPTION2, 1'b1, 32'h6);
		pulse(3'h1, 3'h0);
		pulse(3'h0, 3'h1);
		repeat (6) @(posedge pclk);
		`CHK(maskable_int_req, 1'b1)
		apb(ADDR_ACK, 1'b1, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(maskable_int_req, 1'b0)
		// stop mode, then wake by request
		apb(ADDR_OPTION2, 1'b1, 32'hA);
		repeat (2) @(posedge pclk);
		`CHK(clocks_halted, 1'b1)
		meas(0, 0);
		pulse(3'h1, 3'h0);
		repeat (6) @(posedge pclk);
		`CHK(clocks_halted, 1'b0)
		pulse(3'h0, 3'h1);
		meas(64 / (8 * DIV), 256 / (8 * DIV));
		// failure resets, quick rise is internal, slow rise external
		apb(ADDR_OPTION2, 1'b1, 32'h4);
		fail_once(1'b0);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		`CHK(rd[STS_RST_EXT], 1'b0)
		apb(ADDR_OPTION2, 1'b0, 32'h0);
		`CHK(rd[3:0], 4'h2)
		apb(ADDR_FLAGS, 1'b0, 32'h0);
		`CHK(rd[1:0], 2'h3)
		slow_rise <= 1'b1;
		fail_once(1'b1);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		`CHK(rd[STS_RST_EXT], 1'b1)
		slow_rise <= 1'b0;
		switch_press <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK(internal_reset_n, 1'b0)
		switch_press <= 1'b0;
		give_verdict();
	end
endmodule
